// file: core/dso_strap_dma.sv
/*
 Strap-configured host interface of a disk controller: address decode,
 vector and priority, dma cycle style, parity, write buffer start level.
 Assumes straps are static, host/disk inputs synchronous to clk.
*/
//
// Notes on behaviour
// - the register block base comes from eight straps on address bits 12..5, fitted meaning zero.
// - at most 30 host addresses are decoded, the count set by a strap group.
// - the standard count strap setting exposes 20 registers.
// - the vector comes from seven straps on bits 8..2, fitted meaning one, standard 000254 octal.
// - interrupts are requested at the strap-selected bus priority level, normally level 5.
// - a strap enables a faster dma request path that saves a cycle.
// - missed-transfer errors are detected unless the maintenance strap is removed.
// - the one-cycle strap gives one memory reference per grant, else bursts.
// - with both one-cycle and hold straps cut, the secondary bus is held for whole blocks.
// - each port is set on its own for 16 bits plus parity or 18 data bits.
// - parity strap fitted checks parity on reads, removed carries the lines as bits 16 and 17.
// - a disk write waits for 64, 32, 16 or 1 buffered words as strapped.
// - a strap forces all transfers onto the primary bus whatever software asks.
`timescale 1ns/1ps
`include "dso_defs.svh"
module dso_strap_dma
    import dso_pkg::*;
#(
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // straps
    input wire logic [7:0] strapAddr,
    input wire logic [4:0] strapRegCnt,
    input wire logic [6:0] strapVec,
    input wire logic [1:0] strapPri,
    input wire logic strapFastLat,
    input wire logic strapMxf,
    input wire logic strapOneCyc,
    input wire logic strapHold,
    input wire logic strapParA,
    input wire logic strapParB,
    input wire logic [2:0] strapFill,
    input wire logic strapPriOnly,
    // host address decode
    input wire logic [17:0] hostAddr,
    output logic hostHit,
    output logic [4:0] hostRegIdx,
    // interrupt
    output logic irq,
    output logic [3:0] hostBr,
    output logic [8:0] vector,
    // dma on the host buses
    output logic dmaReq,
    input wire logic dmaGrant,
    output logic busHeld,
    output logic busSelSec,
    output logic memCyc,
    input wire logic memAck,
    input wire logic [15:0] memData,
    input wire logic [1:0] memPar,
    // disk side
    output logic diskGo,
    input wire logic diskWordReq,
    output logic [17:0] diskData,
    output logic diskValid,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // start level from the one-hot fill straps, lowest count if none
    function automatic logic [6:0] startLevel(input logic [2:0] sel);
        if (sel[0]) return `DSO_THR_64;
        else if (sel[1]) return `DSO_THR_32;
        else if (sel[2]) return `DSO_THR_16;
        else return `DSO_THR_1;
    endfunction : startLevel

    // odd parity per byte, pa covers the low byte
    function automatic logic parityOk(input logic [15:0] d,
                                      input logic [1:0] p);
        return (^{p[0], d[7:0]}) & (^{p[1], d[15:8]});
    endfunction : parityOk

    dso_regs_t s, next_s;
    logic [6:0] fill;
    logic room, secEff, holdMode, ackNow, readNow, parOn, goReq;
    logic [3:0] ev;
    logic [17:0] wordIn;
    logic [12:0] offs;

    // ------------------------------------------------------------
    // combinational views of the state
    // ------------------------------------------------------------
    assign fill = s.wrPtr - s.rdPtr;
    assign room = fill < 7'(DEPTH);
    assign secEff = s.reqSec & ~s.sPriOnly;
    assign holdMode = ~s.sOneCyc & ~s.sHold & secEff;
    assign ackNow = (s.st == ST_CYC) & memAck;
    assign readNow = diskWordReq & (fill != 7'h00);
    assign parOn = secEff ? s.sParB : s.sParA;
    // parity lines become data bits 16 and 17 when checking is off
    assign wordIn = parOn ? {2'b00, memData}
                          : {memPar[1], memPar[0], memData};
    assign goReq = regWr & (regAddr == `DSO_REG_CTRL)
                 & regWdata[`DSO_CTRL_GO] & s.sampled;

    // host decode: fitted strap reads zero, so it maps straight onto
    // the address bit; window counted in words
    assign offs = hostAddr[12:0] - {s.sAddr, 5'h00};
    assign hostRegIdx = offs[5:1];
    assign hostHit = s.sampled & (hostAddr[17:13] == `DSO_IO_PAGE)
                   & (offs[12:6] == 7'h00)
                   & (offs[5:1] < s.sRegCnt)
                   & (offs[5:1] < `DSO_MAX_ADDRS);

    // interrupt, vector and priority outputs
    assign irq = |(s.status & s.mask);
    assign hostBr = irq ? (4'h1 << s.sPri) : 4'h0;
    assign vector = {s.sVec, 2'b00};

    // fast path raises the request straight from idle
    assign dmaReq = (s.st == ST_REQ)
                  | (s.sFast & (s.st == ST_IDLE)
                     & s.active & room);
    assign busHeld = (s.st == ST_CYC) | (s.st == ST_HOLD);
    assign memCyc = (s.st == ST_CYC);
    assign busSelSec = secEff;
    assign diskValid = s.diskValid;
    assign regRdata = s.rdData;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        ev = 4'h0;
        diskGo = 1'b0;
        next_s.diskValid = readNow;
        next_s.rdData = 32'h0000_0000;
        // straps caught once, no write path touches them
        if (!s.sampled)
        begin
            next_s.sampled = 1'b1;
            next_s.sAddr = strapAddr;
            next_s.sRegCnt = strapRegCnt;
            next_s.sVec = strapVec;
            next_s.sPri = strapPri;
            next_s.sFast = strapFastLat;
            next_s.sMxfEn = strapMxf;
            next_s.sOneCyc = strapOneCyc;
            next_s.sHold = strapHold;
            next_s.sParA = strapParA;
            next_s.sParB = strapParB;
            next_s.sFill = strapFill;
            next_s.sPriOnly = strapPriOnly;
        end
        // control writes; go is ignored while a transfer runs
        if (regWr && regAddr == `DSO_REG_CTRL)
        begin
            next_s.reqSec = regWdata[`DSO_CTRL_SEC];
        end
        if (regWr && regAddr == `DSO_REG_MASK)
        begin
            next_s.mask = regWdata[3:0];
        end
        if (goReq && !s.active && regWdata[31:16] != 16'h0000)
        begin
            next_s.active = 1'b1;
            next_s.started = 1'b0;
            next_s.wordsLeft = regWdata[31:16];
        end
        // dma sequencer
        unique case (s.st)
            ST_IDLE:
            begin
                if (s.active && room)
                begin
                    if (s.sFast && dmaGrant)
                    begin
                        next_s.st = ST_CYC;
                    end
                    else if (!s.sFast)
                    begin
                        next_s.st = ST_REQ;
                    end
                    next_s.burst = 3'h0;
                end
            end
            ST_REQ:
            begin
                if (dmaGrant)
                begin
                    next_s.st = ST_CYC;
                end
            end
            ST_CYC:
            begin
                if (memAck)
                begin
                    next_s.wrPtr = s.wrPtr + 7'h01;
                    next_s.wordsLeft = s.wordsLeft - 16'h0001;
                    next_s.burst = s.burst + 3'h1;
                    if (parOn && !parityOk(memData, memPar))
                    begin
                        ev[`DSO_ST_PAR] = 1'b1;
                    end
                    if (s.wordsLeft == 16'h0001)
                    begin
                        next_s.st = ST_IDLE;
                        next_s.active = 1'b0;
                        ev[`DSO_ST_DONE] = 1'b1;
                    end
                    else if (s.sOneCyc)
                    begin
                        next_s.st = ST_IDLE;
                    end
                    else if (holdMode)
                    begin
                        next_s.st = (fill + 7'h01 < 7'(DEPTH))
                                  ? ST_CYC : ST_HOLD;
                    end
                    else if (s.burst == `DSO_BURST - 3'h1
                             || fill + 7'h01 >= 7'(DEPTH))
                    begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_HOLD:
            begin
                // mastership kept while the disk drains the buffer
                if (room)
                begin
                    next_s.st = ST_CYC;
                end
            end
        endcase
        // disk write waits for the strapped level, or for the tail
        if (s.active && !s.started
            && (fill >= startLevel(s.sFill)))
        begin
            diskGo = 1'b1;
        end
        if (!s.active && !s.started && fill != 7'h00)
        begin
            diskGo = 1'b1;
        end
        if (diskGo)
        begin
            next_s.started = 1'b1;
            ev[`DSO_ST_WSTART] = 1'b1;
        end
        // disk side reads
        if (readNow)
        begin
            next_s.rdPtr = s.rdPtr + 7'h01;
        end
        if (diskWordReq && s.started && fill == 7'h00
            && s.active && s.sMxfEn)
        begin
            ev[`DSO_ST_MISS] = 1'b1;
        end
        if (!s.active && fill == 7'h00)
        begin
            next_s.started = 1'b0;
        end
        // register reads; status is cleared by its read, set wins
        if (regRd)
        begin
            unique case (regAddr)
                `DSO_REG_CTRL: next_s.rdData = {s.wordsLeft, 13'h0000,
                    s.started, s.active, s.reqSec};
                `DSO_REG_STAT: next_s.rdData = {28'h000_0000, s.status};
                `DSO_REG_MASK: next_s.rdData = {28'h000_0000, s.mask};
                `DSO_REG_STRAP: next_s.rdData = {s.sPriOnly, s.sFill,
                    s.sParB, s.sParA, s.sHold, s.sOneCyc, s.sMxfEn,
                    s.sFast, s.sPri, s.sVec, s.sRegCnt, s.sAddr};
                `DSO_REG_LEVEL: next_s.rdData = {23'h00_0000, s.st,
                    fill};
                default: next_s.rdData = 32'h0000_0000;
            endcase
        end
        next_s.status = ((regRd && regAddr == `DSO_REG_STAT)
                         ? 4'h0 : s.status) | ev;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // buffer between host fetches and disk writes
    dso_buf_mem #(.WIDTH(18), .DEPTH(DEPTH), .AW(6)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(ackNow),
        .wrAddr(s.wrPtr[5:0]),
        .wrData(wordIn),
        .rdEn(readNow),
        .rdAddr(s.rdPtr[5:0]),
        .rdData(diskData)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence q_ack;
        s.st == ST_CYC && memAck;
    endsequence
    sequence q_last_ack;
        s.st == ST_CYC && memAck && s.wordsLeft == 16'h0001;
    endsequence

    property p_one_cycle;
        @(posedge clk) disable iff (sys_rst)
        q_ack and s.sOneCyc |=> !busHeld;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("one-cycle mode kept the bus");

    property p_burst;
        @(posedge clk) disable iff (sys_rst)
        (q_ack and !s.sOneCyc && !holdMode && s.wordsLeft > 16'h0001
         && s.burst == 3'h0 && fill < 7'h3E) |=> busHeld;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst released after first word");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        (q_ack and holdMode && s.wordsLeft > 16'h0001) |=> busHeld;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold mode released the bus");

    property p_done;
        @(posedge clk) disable iff (sys_rst)
        q_last_ack |=> !s.active ##1 !busHeld;
    endproperty
    a_done: assert property (p_done)
        else $error("transfer did not end on last word");

    property p_prim_only;
        @(posedge clk) disable iff (sys_rst)
        s.sampled && s.sPriOnly |-> !busSelSec;
    endproperty
    a_prim_only: assert property (p_prim_only)
        else $error("secondary bus used while forced primary");

    property p_start;
        @(posedge clk) disable iff (sys_rst)
        diskGo && s.active |-> fill >= startLevel(s.sFill);
    endproperty
    a_start: assert property (p_start)
        else $error("disk write started below level");

    property p_parity;
        @(posedge clk) disable iff (sys_rst)
        (q_ack and parOn && !parityOk(memData, memPar))
        |=> s.status[`DSO_ST_PAR];
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity error not flagged");

    property p_miss;
        @(posedge clk) disable iff (sys_rst)
        diskWordReq && s.started && fill == 7'h00 && s.active
        |=> s.status[`DSO_ST_MISS] == $past(s.sMxfEn)
            || $past(s.status[`DSO_ST_MISS]);
    endproperty
    a_miss: assert property (p_miss)
        else $error("missed transfer handling wrong");

    property p_static;
        @(posedge clk) disable iff (sys_rst)
        s.sampled |=> $stable(s.sVec) && $stable(s.sAddr)
                      && $stable(s.sFill) && $stable(s.sPriOnly);
    endproperty
    a_static: assert property (p_static)
        else $error("strap copy changed after sampling");

    property p_hit;
        @(posedge clk) disable iff (sys_rst)
        hostHit |-> hostRegIdx < s.sRegCnt
                    && hostRegIdx < `DSO_MAX_ADDRS;
    endproperty
    a_hit: assert property (p_hit)
        else $error("decode answered beyond register count");

    property p_fast;
        @(posedge clk) disable iff (sys_rst)
        s.sampled && s.sFast && s.st == ST_IDLE && s.active && room
        |-> dmaReq;
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast request path not raised");

endmodule : dso_strap_dma

// file: core/dso_defs.svh
/*
 Constants of the disk controller strap-option block: register offsets,
 status bits, reset values, host decode figures, thresholds and burst length.
 Assumes it is included by bare name from the main module and the bench.
*/
`ifndef DSO_DEFS_SVH
`define DSO_DEFS_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define DSO_REG_CTRL 3'h0
`define DSO_REG_STAT 3'h1
`define DSO_REG_MASK 3'h2
`define DSO_REG_STRAP 3'h3
`define DSO_REG_LEVEL 3'h4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DSO_CTRL_SEC 0
`define DSO_CTRL_GO 1
`define DSO_ST_DONE 0
`define DSO_ST_PAR 1
`define DSO_ST_MISS 2
`define DSO_ST_WSTART 3
`define DSO_MASK_RST 4'h0
`define DSO_STAT_RST 4'h0

// ----------------------------------------------------------------
// host address space and decode figures
// ----------------------------------------------------------------
`define DSO_IO_PAGE 5'h1F
`define DSO_STD_FIRST 18'h3_FDC0
`define DSO_STD_LAST 18'h3_FDE6
`define DSO_MAX_ADDRS 5'h1E
`define DSO_STD_REGS 5'h14
`define DSO_STD_VECTOR 9'h0AC

// ----------------------------------------------------------------
// write-start thresholds and burst length
// ----------------------------------------------------------------
`define DSO_THR_64 7'h40
`define DSO_THR_32 7'h20
`define DSO_THR_16 7'h10
`define DSO_THR_1 7'h01
`define DSO_BURST 3'h4

`endif

// file: core/dso_pkg.sv
/*
 Types of the disk controller strap-option block: DMA states and the
 packed state record of the main module.
 Assumes dso_defs.svh is on the include path.
*/
package dso_pkg;

    // ------------------------------------------------------------
    // dma sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_CYC, ST_HOLD} dso_state_t;

    // ------------------------------------------------------------
    // whole state of the main module
    // ------------------------------------------------------------
    typedef struct packed {
        dso_state_t st;
        logic sampled;
        logic [7:0] sAddr;
        logic [4:0] sRegCnt;
        logic [6:0] sVec;
        logic [1:0] sPri;
        logic sFast;
        logic sMxfEn;
        logic sOneCyc;
        logic sHold;
        logic sParA;
        logic sParB;
        logic [2:0] sFill;
        logic sPriOnly;
        logic reqSec;
        logic active;
        logic started;
        logic [15:0] wordsLeft;
        logic [2:0] burst;
        logic [6:0] wrPtr;
        logic [6:0] rdPtr;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdData;
        logic diskValid;
    } dso_regs_t;

endpackage : dso_pkg

// file: core/dso_buf_mem.sv
/*
 Write buffer memory: one write port, one read port with registered data.
 Assumes the owner keeps the pointers and never reads an empty slot.
*/
`timescale 1ns/1ps
module dso_buf_mem #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read side
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    // storage array, no reset so it maps to ram
    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read data
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdData <= '0;
        end
        else if (rdEn)
        begin
            rdData <= mem[rdAddr];
        end
    end

endmodule : dso_buf_mem

// file: testbench/dso_host_model.sv
/*
 Host memory and bus arbiter model facing the strap dma block.
 Assumes one clock; the bench sets answer latency and bad parity.
*/
`timescale 1ns/1ps
module dso_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host bus side
    input wire logic dmaReq,
    input wire logic memCyc,
    output logic dmaGrant,
    output logic memAck,
    output logic [15:0] memData,
    output logic [1:0] memPar,
    // bench controls and counts
    input wire logic [3:0] lat,
    input wire logic badPar,
    output int grants,
    output int acks
);
    logic [3:0] cnt;
    logic [15:0] w;

    // ------------------------------------------------------------
    // grant one cycle after a request, answer lat+1 cycles into a memory cycle
    // ------------------------------------------------------------
    assign w = 16'hA500 + acks[15:0];
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dmaGrant <= 1'b0;
            memAck <= 1'b0;
            cnt <= 4'h0;
            grants <= 0;
            acks <= 0;
            memData <= 16'h0000;
            memPar <= 2'b00;
        end
        else
        begin
            dmaGrant <= dmaReq && !dmaGrant;
            if (dmaReq && !dmaGrant)
                grants <= grants + 1;
            memAck <= 1'b0;
            // released lines keep toggling, never a stale word
            memData <= ~memData;
            memPar <= ~memPar;
            cnt <= 4'h0;
            if (memAck)
                acks <= acks + 1;
            else if (memCyc && cnt >= lat)
            begin
                memAck <= 1'b1;
                memData <= w;
                memPar <= {~^w[15:8], (~^w[7:0]) ^ badPar};
            end
            else if (memCyc)
                cnt <= cnt + 4'h1;
        end
    end
endmodule : dso_host_model

// file: testbench/test_dso_strap_dma.sv
/*
 Self-checking bench of the strap dma block with a host model.
 Assumes straps change only while reset is held.
*/
`timescale 1ns/1ps
`include "dso_defs.svh"
module test_dso_strap_dma
    import dso_pkg::*;
;
    logic clk, sys_rst, strapFastLat, strapMxf, strapOneCyc, strapHold;
    logic strapParA, strapParB, strapPriOnly, hostHit, irq, dmaReq;
    logic dmaGrant, busHeld, busSelSec, memCyc, memAck, diskGo;
    logic diskWordReq, diskValid, regWr, regRd, badPar, sawSec, goSeen;
    logic [7:0] strapAddr = 8'hEE;
    logic [4:0] strapRegCnt = 5'h14;
    logic [6:0] strapVec = 7'h2B;
    logic [1:0] strapPri = 2'h1;
    logic [2:0] strapFill, regAddr;
    logic [17:0] hostAddr, diskData;
    logic [4:0] hostRegIdx;
    logic [3:0] hostBr, lat;
    logic [8:0] vector;
    logic [15:0] memData;
    logic [1:0] memPar;
    logic [31:0] regWdata, regRdata;
    int grants, acks, goAcks, err_total, checked;

    dso_strap_dma uut (.clk, .sys_rst, .strapAddr, .strapRegCnt,
        .strapVec, .strapPri, .strapFastLat, .strapMxf, .strapOneCyc,
        .strapHold, .strapParA, .strapParB, .strapFill, .strapPriOnly,
        .hostAddr, .hostHit, .hostRegIdx, .irq, .hostBr, .vector,
        .dmaReq, .dmaGrant, .busHeld, .busSelSec, .memCyc, .memAck,
        .memData, .memPar, .diskGo, .diskWordReq, .diskData, .diskValid,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    dso_host_model host (.clk, .sys_rst, .dmaReq, .memCyc, .dmaGrant,
        .memAck, .memData, .memPar, .lat, .badPar, .grants, .acks);

    // clock of 4 ns
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // bus port and first write-start level seen
    always @(posedge clk)
    begin
        if (memCyc === 1'b1)
            sawSec <= busSelSec;
        if (diskGo === 1'b1 && goSeen !== 1'b1)
        begin
            goSeen <= 1'b1;
            goAcks <= acks;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // bounded wait; running out ends the run
    task automatic wait_on(ref logic s, input int n);
        int i;
        for (i = 0; i < n && s !== 1'b1; i++)
            @(posedge clk) #1;
        if (s !== 1'b1)
        begin
            err_total++;
            end_sim();
        end
    endtask : wait_on

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    // c: fast parB priOnly mxf parA hold oneCyc fill[2:0]
    task automatic boot(input logic [9:0] c);
        @(posedge clk);
        sys_rst <= 1'b1;
        goSeen <= 1'b0;
        {strapFastLat, strapParB, strapPriOnly, strapMxf, strapParA,
            strapHold, strapOneCyc, strapFill} <= c;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : boot

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_decode();
        logic [17:0] a [4] = '{18'h3_FDC0, 18'h3_FDE6, 18'h3_FDE8,
            18'h3_FDBE};
        int i;
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            hostAddr <= a[i];
            @(posedge clk) #1;
            chk("hit", hostHit, i < 2);
            if (i < 2)
                chk("idx", hostRegIdx, (a[i] - `DSO_STD_FIRST) >> 1);
        end
    endtask : s_decode

    task automatic s_straps();
        logic [31:0] d;
        chk("vector", vector, `DSO_STD_VECTOR);
        wr(`DSO_REG_STRAP, 32'h0000_0000);
        rd(`DSO_REG_STRAP, d);
        chk("straps", d, 32'h1E95_74EE);
        rd(3'h7, d);
        chk("unmapped", d, 32'h0000_0000);
        rd(`DSO_REG_MASK, d);
        chk("mask", d, 32'h0000_0000);
    endtask : s_straps

    // eight words, then drain them on the disk side
    task automatic s_dma(input logic [9:0] c, input logic sec, bad,
        input int g);
        logic [31:0] d;
        logic [15:0] w;
        logic pc;
        int i;
        pc = (sec && !c[7]) ? c[8] : c[5];
        boot(c);
        badPar <= bad;
        wr(`DSO_REG_MASK, 32'h0000_0001);
        wr(`DSO_REG_CTRL, {16'h0008, 14'h0000, 1'b1, sec});
        wait_on(irq, 400);
        chk("br", hostBr, 4'h2);
        chk("grants", grants, g);
        chk("port", sawSec, sec && !c[7]);
        rd(`DSO_REG_STAT, d);
        chk("status", d[1:0], {bad && pc, 1'b1});
        chk("irq", irq, 1'b0);
        chk("br idle", hostBr, 4'h0);
        for (i = 0; i < 8; i++)
        begin
            w = 16'hA500 + i[15:0];
            @(posedge clk);
            diskWordReq <= 1'b1;
            @(posedge clk);
            diskWordReq <= 1'b0;
            #1 chk("word", {diskValid, pc ? {2'b00, diskData[15:0]} :
                diskData}, {1'b1, pc ? 2'b00 : {~^w[15:8], ~^w[7:0]},
                w});
        end
    endtask : s_dma

    task automatic s_fill();
        logic [2:0] f [5] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b110};
        int t [5] = '{64, 32, 16, 1, 32};
        int i;
        lat <= 4'h2;
        for (i = 0; i < 5; i++)
        begin
            boot({7'b0101110, f[i]});
            wr(`DSO_REG_CTRL, 32'h0040_0002);
            wait_on(goSeen, 2000);
            chk("start", goAcks, t[i]);
        end
    endtask : s_fill

    // second request finds the buffer empty while words trickle in
    task automatic s_miss();
        logic [31:0] d;
        int m;
        lat <= 4'hF;
        for (m = 0; m < 2; m++)
        begin
            boot({3'b010, m[0], 6'b110000});
            wr(`DSO_REG_CTRL, 32'h0004_0002);
            wait_on(goSeen, 400);
            @(posedge clk);
            diskWordReq <= 1'b1;
            repeat (2) @(posedge clk);
            diskWordReq <= 1'b0;
            rd(`DSO_REG_STAT, d);
            chk("missed", d[2], m[0]);
        end
    endtask : s_miss

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {sys_rst, regWr, regRd, diskWordReq, badPar} = 5'b10000;
        {regAddr, regWdata, hostAddr, lat} = '0;
        boot(10'h171);
        s_decode();
        s_straps();
        s_dma(10'h171, 1'b0, 1'b0, 8 / `DSO_BURST);
        s_dma(10'h371, 1'b0, 1'b0, 8 / `DSO_BURST);
        s_dma(10'h179, 1'b0, 1'b0, 8);
        s_dma(10'h061, 1'b1, 1'b0, 1);
        s_dma(10'h1E1, 1'b1, 1'b0, 8 / `DSO_BURST);
        s_dma(10'h171, 1'b0, 1'b1, 8 / `DSO_BURST);
        s_dma(10'h151, 1'b0, 1'b0, 8 / `DSO_BURST);
        s_fill();
        s_miss();
        end_sim();
    end
endmodule : test_dso_strap_dma
